// [logic/cbsd_fifo.sv]
/*
 Dual-clock FIFO with gray-coded pointers and a registered read stage.
 Assumes each side's reset is synchronous to that side's clock.
*/
`timescale 1ns/1ps
module cbsd_fifo #(
   parameter int W = 34,
   parameter int DEPTH = 32
) (
   input wire logic i_wr_clk,
   input wire logic i_wr_rst,
   input wire logic i_wr_valid,
   input wire logic [W-1:0] i_wr_data,
   output logic o_wr_ready,
   input wire logic i_rd_clk,
   input wire logic i_rd_rst,
   output logic o_rd_valid,
   output logic [W-1:0] o_rd_data,
   input wire logic i_rd_ready
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 4 || (1 << AW) != DEPTH || W < 1) begin
         $error("cbsd_fifo: DEPTH must be a power of two of at least 4");
      end
   end

   typedef struct packed {
      logic [AW:0] bin;
      logic [AW:0] gray;
   } cbsd_wr_st_t;

   typedef struct packed {
      logic [AW:0] bin;
      logic [AW:0] gray;
      logic valid;
      logic [W-1:0] data;
   } cbsd_rd_st_t;

   logic [W-1:0] mem [DEPTH];
   cbsd_wr_st_t w;
   cbsd_wr_st_t next_w;
   cbsd_rd_st_t r;
   cbsd_rd_st_t next_r;
   logic [AW:0] rgray_s;
   logic [AW:0] wgray_s;
   logic full;
   logic empty;
   logic push;
   logic load;

   cbsd_sync #(.W(AW + 1)) u_rsync (.i_clk(i_wr_clk), .i_d(r.gray), .o_q(rgray_s));
   cbsd_sync #(.W(AW + 1)) u_wsync (.i_clk(i_rd_clk), .i_d(w.gray), .o_q(wgray_s));

   assign full = (w.gray == {~rgray_s[AW:AW-1], rgray_s[AW-2:0]});
   assign empty = (r.gray == wgray_s);
   assign o_wr_ready = !full;
   assign push = i_wr_valid && !full;
   assign load = !empty && (!r.valid || i_rd_ready);

   always_comb begin
      next_w = w;
      if (push) begin
         next_w.bin = w.bin + 1'b1;
         next_w.gray = next_w.bin ^ (next_w.bin >> 1);
      end
   end

   always_ff @(posedge i_wr_clk) begin
      if (i_wr_rst) begin
         w <= '0;
      end else begin
         w <= next_w;
      end
   end

   always_ff @(posedge i_wr_clk) begin
      if (push) begin
         mem[w.bin[AW-1:0]] <= i_wr_data;
      end
   end

   always_comb begin
      next_r = r;
      if (load) begin
         next_r.data = mem[r.bin[AW-1:0]];
         next_r.valid = 1'b1;
         next_r.bin = r.bin + 1'b1;
         next_r.gray = next_r.bin ^ (next_r.bin >> 1);
      end else if (i_rd_ready) begin
         next_r.valid = 1'b0;
      end
   end

   always_ff @(posedge i_rd_clk) begin
      if (i_rd_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign o_rd_valid = r.valid;
   assign o_rd_data = r.data;
endmodule

// [logic/cbsd_pkg.sv]
/*
 Shared types and constants of the processor bus status decoder probe.
 Assumes a multiplexed-bus 8-bit processor whose pins are synchronous to its clock output.
*/
package cbsd_pkg;

   localparam int CBSD_DATA_W = 8;
   localparam int CBSD_ADDR_W = 16;
   localparam int CBSD_CTRL_W = 10;
   localparam int CBSD_CHAN_N = CBSD_DATA_W + CBSD_ADDR_W + CBSD_CTRL_W;
   localparam int CBSD_IRQ_N = 5;
   localparam int CBSD_FIFO_DEPTH = 32;

   // Control channel positions
   localparam int C_RW = 0;
   localparam int C_IOM = 1;
   localparam int C_PEND = 2;
   localparam int C_FETCH = 3;
   localparam int C_IACK = 4;
   localparam int C_HOLD = 5;
   localparam int C_RSTO = 6;
   localparam int C_STOP = 7;
   localparam int C_SYNC_N = 8;
   localparam int C_WAIT = 9;

   localparam logic [CBSD_CTRL_W-1:0] CBSD_CTRL_RST = 10'h000;
   localparam logic [7:0] CBSD_LO_RST = 8'h00;

   typedef struct packed {
      logic [7:0] ad;
      logic [7:0] a_hi;
      logic status_bit_zero;
      logic status_bit_one;
      logic io_m;
      logic ale;
      logic interrupt_ack_strobe_n;
      logic ready;
      logic hold;
      logic halt_n;
      logic reset_out;
   } cbsd_pins_t;

   typedef struct packed {
      logic [CBSD_DATA_W-1:0] data;
      logic [CBSD_ADDR_W-1:0] addr;
      logic [CBSD_CTRL_W-1:0] ctrl;
   } cbsd_sample_t;

   // Idle covers any state after T3 until the next cycle start
   typedef enum logic [2:0] {TS_IDLE, TS_T1, TS_T2, TS_TW, TS_T3} cbsd_tstate_t;

endpackage

// [logic/cbsd_sync.sv]
/*
 Two flip-flop synchroniser for levels, toggles and gray-coded pointers.
 Assumes each bit changes alone or the word is gray coded.
*/
`timescale 1ns/1ps
module cbsd_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } cbsd_sync_st_t;

   cbsd_sync_st_t s;
   cbsd_sync_st_t next_s;

   // No reset: the first stage must feed only the second
   always_comb begin
      next_s.meta = i_d;
      next_s.q = s.meta;
   end

   always_ff @(posedge i_clk) begin
      s <= next_s;
   end

   assign o_q = s.q;
endmodule

// [logic/cbsd_top.sv]
/*
 Bus status decoder probe: watches the processor pins on the processor clock,
 decodes ten control channels, latches the low address byte and streams
 34-channel samples, one per clock state, through a FIFO to the analyzer side.
 Assumes processor pins are synchronous to i_cpu_clk; interrupt inputs are not.
*/
// Contract
// - Fetch channel when both status high, memory
// - Acknowledge channel when status and port all high
// - Acknowledge strobe low also marks fetch channel
// - Stopped when stop low, ready low, hold high
// - Wait channel follows ready low
// - Any interrupt input raises pending channel
// - Low address latched at strobe trailing edge
// - Channels ordered C0 to C9 as listed
// - Samples carry 8 data, 16 address, 10 control
// - Read is 1, write is 0
// - Everything runs per processor clock state
// - Ready sampled at second state edge
// - Forward all address, data and status lines; status_bit_zero is only decoded, not forwarded
// - Pending holds through one full fetch cycle
// - Port channel 1 for port, 0 memory
`timescale 1ns/1ps
module cbsd_top #(
   parameter int FIFO_DEPTH = cbsd_pkg::CBSD_FIFO_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_cpu_clk,
   input wire cbsd_pkg::cbsd_pins_t i_pins,
   input wire logic [cbsd_pkg::CBSD_IRQ_N-1:0] i_irq,
   output cbsd_pkg::cbsd_sample_t o_sample,
   output logic o_sample_valid,
   input wire logic i_sample_ready,
   output logic o_overflow,
   input wire logic i_overflow_clr
);
   import cbsd_pkg::*;

   initial begin
      if (FIFO_DEPTH < 4) begin
         $error("cbsd_top: FIFO_DEPTH must be at least 4");
      end
   end

   typedef struct packed {
      cbsd_pins_t p;
      cbsd_tstate_t ts;
      logic [CBSD_CTRL_W-1:0] ctrl;
      logic [7:0] lo;
      logic [7:0] dat;
      logic [7:0] ahi;
      logic pend;
      logic fetch_seen;
      logic run;
      logic ovf_tgl;
   } cbsd_link_st_t;

   typedef struct packed {
      logic tgl_d;
      logic ovf;
   } cbsd_sys_st_t;

   cbsd_link_st_t l;
   cbsd_link_st_t next_l;
   cbsd_sys_st_t s;
   cbsd_sys_st_t next_s;
   logic link_rst;
   logic [CBSD_IRQ_N-1:0] irq_s;
   logic irq_any;
   logic dec_fetch;
   logic dec_iack;
   logic wr_ready;
   logic ovf_tgl_s;
   cbsd_sample_t wr_sample;

   // Reset is taken over into the processor clock; that clock must run during reset
   cbsd_sync #(.W(1)) u_rst_sync (.i_clk(i_cpu_clk), .i_d(i_rst), .o_q(link_rst));
   cbsd_sync #(.W(CBSD_IRQ_N)) u_irq_sync (.i_clk(i_cpu_clk), .i_d(i_irq), .o_q(irq_s));
   cbsd_sync #(.W(1)) u_ovf_sync (.i_clk(i_clk), .i_d(l.ovf_tgl), .o_q(ovf_tgl_s));

   assign irq_any = |irq_s;
   assign dec_fetch = l.p.status_bit_zero && l.p.status_bit_one
      && (!l.p.io_m || !l.p.interrupt_ack_strobe_n);
   assign dec_iack = l.p.status_bit_zero && l.p.status_bit_one && l.p.io_m;

   always_comb begin
      next_l = l;
      next_l.p = i_pins;
      next_l.dat = l.p.ad;
      next_l.ahi = l.p.a_hi;
      // Last value while the strobe is high is the one at its trailing edge
      if (l.p.ale) begin
         next_l.lo = l.p.ad;
      end
      // T-state tracking, one step per processor clock cycle
      if (i_pins.ale) begin
         next_l.ts = TS_T1;
      end else begin
         case (l.ts)
            TS_T1: next_l.ts = TS_T2;
            TS_T2: next_l.ts = l.p.ready ? TS_T3 : TS_TW;
            TS_TW: next_l.ts = l.p.ready ? TS_T3 : TS_TW;
            default: next_l.ts = TS_IDLE;
         endcase
      end
      // Processor reset output dominates the interrupt latch
      if (l.p.reset_out) begin
         next_l.pend = 1'b0;
         next_l.fetch_seen = 1'b0;
      end else if (irq_any) begin
         next_l.pend = 1'b1;
         next_l.fetch_seen = 1'b0;
      end else if (l.pend && l.fetch_seen && l.p.ale) begin
         next_l.pend = 1'b0;
         next_l.fetch_seen = 1'b0;
      end else if (l.pend && dec_fetch) begin
         next_l.fetch_seen = 1'b1;
      end
      next_l.ctrl[C_RW] = l.p.status_bit_one;
      next_l.ctrl[C_IOM] = l.p.io_m;
      next_l.ctrl[C_PEND] = next_l.pend;
      next_l.ctrl[C_FETCH] = dec_fetch;
      next_l.ctrl[C_IACK] = dec_iack;
      next_l.ctrl[C_HOLD] = l.p.hold;
      next_l.ctrl[C_RSTO] = l.p.reset_out;
      next_l.ctrl[C_STOP] = !l.p.halt_n || !l.p.ready || l.p.hold;
      next_l.ctrl[C_SYNC_N] = !l.p.ale;
      next_l.ctrl[C_WAIT] = (l.ts == TS_TW);
      next_l.run = 1'b1;
      // A full FIFO drops the sample; the processor cannot be stalled
      if (l.run && !wr_ready) begin
         next_l.ovf_tgl = !l.ovf_tgl;
      end
   end

   always_ff @(posedge i_cpu_clk) begin
      if (link_rst) begin
         l <= '0;
      end else begin
         l <= next_l;
      end
   end

   assign wr_sample.data = l.dat;
   assign wr_sample.addr = {l.ahi, l.lo};
   assign wr_sample.ctrl = l.ctrl;

   cbsd_fifo #(.W(CBSD_CHAN_N), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_wr_clk(i_cpu_clk),
      .i_wr_rst(link_rst),
      .i_wr_valid(l.run),
      .i_wr_data(wr_sample),
      .o_wr_ready(wr_ready),
      .i_rd_clk(i_clk),
      .i_rd_rst(i_rst),
      .o_rd_valid(o_sample_valid),
      .o_rd_data(o_sample),
      .i_rd_ready(i_sample_ready)
   );

   // Overflow flag: a new drop wins over a clear in the same cycle
   always_comb begin
      next_s = s;
      next_s.tgl_d = ovf_tgl_s;
      if (ovf_tgl_s != s.tgl_d) begin
         next_s.ovf = 1'b1;
      end else if (i_overflow_clr) begin
         next_s.ovf = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_overflow = s.ovf;

   // Checks in the processor clock domain
   default clocking cb_link @(posedge i_cpu_clk);
   endclocking
   default disable iff (link_rst);

   AST_FETCH_DECODE: assert property (
      (l.p.status_bit_zero && l.p.status_bit_one && !l.p.io_m) |=> l.ctrl[C_FETCH])
      else $error("fetch channel missing for fetch status");

   AST_IACK_DECODE: assert property (
      (l.p.status_bit_zero && l.p.status_bit_one && l.p.io_m) |=> l.ctrl[C_IACK])
      else $error("acknowledge channel missing");

   AST_IACK_FETCH: assert property (
      (dec_iack && !l.p.interrupt_ack_strobe_n) |=> (l.ctrl[C_FETCH] && l.ctrl[C_IACK]))
      else $error("first acknowledge cycle not marked as fetch");

   // The first edge after reset would compare the cleared word with reset-time pins
   AST_STOPPED: assert property (
      !$past(link_rst)
      |-> (l.ctrl[C_STOP] == $past(!l.p.halt_n || !l.p.ready || l.p.hold)))
      else $error("stopped channel wrong");

   AST_WAIT_STATE: assert property (
      (l.ts == TS_T2 && !l.p.ready && !i_pins.ale) |=> ##1 l.ctrl[C_WAIT])
      else $error("wait channel missing after ready low");

   AST_IRQ_SET: assert property (
      (irq_any && !l.p.reset_out) |=> (l.pend && l.ctrl[C_PEND]))
      else $error("pending channel not raised");

   AST_LO_ADDR: assert property (
      $fell(l.p.ale) |-> (l.lo == $past(l.p.ad)))
      else $error("low address not latched at trailing edge");

   AST_RW_ORDER: assert property (
      !$past(link_rst) |-> ((l.ctrl[C_RW] == $past(l.p.status_bit_one))
      && (l.ctrl[C_SYNC_N] == $past(!l.p.ale))))
      else $error("read-write or sync channel wrong");

   AST_PEND_HOLD: assert property (
      (l.pend && !l.fetch_seen && !l.p.reset_out) |=> l.pend)
      else $error("pending dropped before a fetch cycle");

   AST_RESET_CLR: assert property (
      l.p.reset_out |=> (!l.pend && !l.ctrl[C_PEND]))
      else $error("pending not cleared by processor reset");

   AST_NO_DECODE: assert property (
      !(l.p.status_bit_zero && l.p.status_bit_one) |=> (!l.ctrl[C_FETCH] && !l.ctrl[C_IACK]))
      else $error("fetch or acknowledge on other status");

   AST_PORT_MEM: assert property (
      !$past(link_rst) |-> (l.ctrl[C_IOM] == $past(l.p.io_m)))
      else $error("port-or-memory channel wrong");

   AST_HOLD_CHAN: assert property (
      !$past(link_rst) |-> (l.ctrl[C_HOLD] == $past(l.p.hold)))
      else $error("hold channel wrong");

   AST_RSTO_CHAN: assert property (
      !$past(link_rst) |-> (l.ctrl[C_RSTO] == $past(l.p.reset_out)))
      else $error("reset output channel wrong");

   AST_DATA_FWD: assert property (
      !$past(link_rst) |-> (l.dat == $past(l.p.ad)))
      else $error("data byte not forwarded");

   AST_AHI_FWD: assert property (
      !$past(link_rst) |-> (l.ahi == $past(l.p.a_hi)))
      else $error("high address byte not forwarded");

   AST_LO_HOLD: assert property (
      (!$past(link_rst) && !$past(l.p.ale)) |-> $stable(l.lo))
      else $error("low address changed without strobe");

   AST_NO_WAIT: assert property (
      (l.ts == TS_T2 && l.p.ready) |=> ##1 !l.ctrl[C_WAIT])
      else $error("wait channel set although ready was high");

   AST_PEND_CHAN: assert property (
      l.ctrl[C_PEND] == l.pend)
      else $error("pending channel differs from latch");

   AST_TS_START: assert property (
      i_pins.ale |=> (l.ts == TS_T1))
      else $error("strobe did not start a machine cycle");

   AST_TS_STEP: assert property (
      (l.ts == TS_T1 && !i_pins.ale) |=> (l.ts == TS_T2))
      else $error("first state not followed by second");

   AST_IACK_ONLY: assert property (
      (!$past(link_rst) && l.ctrl[C_IACK]) |-> $past(l.p.io_m))
      else $error("acknowledge channel on memory status");

   AST_FETCH_ONLY: assert property (
      (!$past(link_rst) && l.ctrl[C_FETCH])
      |-> $past(l.p.status_bit_zero && l.p.status_bit_one))
      else $error("fetch channel without fetch status");

   // Checks in the analyzer clock domain
   AST_STREAM_HOLD: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (o_sample_valid && !i_sample_ready) |=> (o_sample_valid && $stable(o_sample)))
      else $error("sample changed before it was taken");

   AST_OVF_SET: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (ovf_tgl_s != s.tgl_d) |=> o_overflow)
      else $error("dropped sample not flagged");

   AST_OVF_CLR: assert property (
      @(posedge i_clk) disable iff (i_rst)
      (i_overflow_clr && ovf_tgl_s == s.tgl_d) |=> !o_overflow)
      else $error("overflow flag not cleared");

   COV_FETCH: cover property (l.ctrl[C_FETCH] && !l.ctrl[C_IACK]);
   COV_IACK_FETCH: cover property (l.ctrl[C_FETCH] && l.ctrl[C_IACK]);
   COV_WAIT: cover property (l.ctrl[C_WAIT] [*2]);
   COV_PEND_CLEAR: cover property (l.pend ##1 !l.pend);
   COV_DROP: cover property (l.run && !wr_ready);

endmodule

// [test/cbsd_analyzer_model.sv]
/*
 Analyzer acquisition side: takes 34-channel samples with random back-pressure.
 Assumes the probe's valid/ready stream, sampled on rising i_clk edges.
*/
`timescale 1ns/1ps
module cbsd_analyzer_model (
   input wire logic i_clk,
   input wire logic i_stall,
   input wire logic i_valid,
   output logic o_ready,
   output logic o_take
);
   integer seed = 32'hD2015E3E;
   // Random gaps mimic a slow acquisition memory; stall forces the probe to drop
   always @(negedge i_clk) begin
      o_ready <= !i_stall && (($random(seed) & 3) != 0);
   end
   // One stored word per accepted sample
   assign o_take = i_valid && o_ready;
endmodule

// [test/cbsd_top_tb.sv]
/*
 Self-checking bench of the bus status decoder probe.
 Assumes the analyzer model drives ready; processor pins change at cpu falling edges.
*/
`timescale 1ns/1ps
module cbsd_top_tb;
   import cbsd_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_cpu_clk = 1'b0;
   cbsd_pins_t pins = '0;
   logic [CBSD_IRQ_N-1:0] irq = '0;
   cbsd_sample_t o_sample;
   logic o_sample_valid;
   logic o_overflow;
   logic rdy;
   logic take;
   logic stall = 1'b1;
   logic clr = 1'b0;
   integer seed = 32'hD2015E3E;
   integer bad_count = 0;
   integer compares = 0;
   cbsd_sample_t exp_q[$];
   cbsd_sample_t last;
   logic have_last = 1'b0;

   always #10 i_clk = ~i_clk;
   // Offset start keeps the processor clock out of phase with i_clk
   initial begin
      #7;
      forever #40 i_cpu_clk = ~i_cpu_clk;
   end

   cbsd_top #(.FIFO_DEPTH(8)) dut (.i_clk(i_clk), .i_rst(i_rst), .i_cpu_clk(i_cpu_clk),
      .i_pins(pins), .i_irq(irq), .o_sample(o_sample), .o_sample_valid(o_sample_valid),
      .i_sample_ready(rdy), .o_overflow(o_overflow), .i_overflow_clr(clr));
   cbsd_analyzer_model partner (.i_clk(i_clk), .i_stall(stall), .i_valid(o_sample_valid),
      .o_ready(rdy), .o_take(take));

   task automatic check(input logic [33:0] seen, input logic [33:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("Counts: %0d compares, %0d mismatches", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic cyc(input cbsd_pins_t p);
      @(negedge i_cpu_clk);
      pins = p;
   endtask

   // One machine cycle: pending cleared, strobe with low address, then steady status.
   // Ready is held for the whole cycle so its state at T2 sets the wait outcome.
   task automatic vec(input logic [7:0] tag, input logic [2:0] st, input logic note);
      cbsd_pins_t p;
      cbsd_sample_t e;
      logic [7:0] lo;
      p = 25'($random(seed));
      irq = 5'($random(seed));
      p.a_hi = tag;
      {p.status_bit_zero, p.status_bit_one, p.io_m} = st;
      p.ale = 1'b0;
      p.reset_out = 1'b1;
      cyc(p);
      p.ale = 1'b1;
      p.reset_out = 1'($random(seed));
      lo = p.ad;
      cyc(p);
      p.ale = 1'b0;
      for (int k = 0; k < 7; k++) begin
         p.ad = 8'($random(seed));
         cyc(p);
      end
      e.data = p.ad;
      e.addr = {tag, lo};
      e.ctrl = '0;
      e.ctrl[C_RW] = p.status_bit_one;
      e.ctrl[C_IOM] = p.io_m;
      e.ctrl[C_PEND] = (|irq) && !p.reset_out;
      e.ctrl[C_FETCH] = p.status_bit_zero && p.status_bit_one
         && (!p.io_m || !p.interrupt_ack_strobe_n);
      e.ctrl[C_IACK] = p.status_bit_zero && p.status_bit_one && p.io_m;
      e.ctrl[C_HOLD] = p.hold;
      e.ctrl[C_RSTO] = p.reset_out;
      e.ctrl[C_STOP] = !p.halt_n || !p.ready || p.hold;
      e.ctrl[C_SYNC_N] = 1'b1;
      e.ctrl[C_WAIT] = !p.ready;
      if (note)
         exp_q.push_back(e);
   endtask

   // Last word of each tagged cycle is compared once the next tag shows up
   always @(posedge i_clk) begin
      if (!i_rst && take) begin
         if (have_last && o_sample.addr[15:8] !== last.addr[15:8] && exp_q.size() > 0
            && exp_q[0].addr[15:8] === last.addr[15:8]) begin
            check(last, exp_q[0]);
            void'(exp_q.pop_front());
         end
         last <= o_sample;
         have_last <= 1'b1;
      end
   end

   initial begin
      // Reset spans enough processor clock edges to reach that domain
      repeat (5) @(posedge i_cpu_clk);
      @(negedge i_clk);
      check(34'(o_sample_valid), 34'h0);
      check(34'(o_overflow), 34'h0);
      i_rst = 1'b0;
      for (int i = 0; i < 3; i++)
         vec(8'hFF, 3'b000, 1'b0);
      check(34'(o_overflow), 34'h1);
      stall = 1'b0;
      repeat (60) @(negedge i_clk);
      clr = 1'b1;
      @(negedge i_clk);
      clr = 1'b0;
      @(negedge i_clk);
      check(34'(o_overflow), 34'h0);
      $display("Overflow test done");
      for (int i = 0; i < 40; i++) begin
         vec(8'(i + 1), 3'(i), 1'b1);
         $display("Cycle test %0d done", i);
      end
      vec(8'h00, 3'b000, 1'b0);
      for (int i = 0; i < 400 && exp_q.size() > 0; i++)
         @(negedge i_clk);
      if (exp_q.size() > 0) begin
         bad_count++;
         $display("ERROR at %0t: %0d samples never arrived", $time, exp_q.size());
      end
      conclude();
   end
endmodule
